//--- scdp_axis_if.sv
`timescale 1ns/1ps
// Per-axis control and status bundle
interface scdp_axis_if;
  logic        start;
  logic        dir_minus;
  logic        fixed;
  logic        dec_stop;
  logic        hard_stop;
  logic        slope_clr;
  logic [31:0] pulses;
  logic [15:0] init_sp;
  logic [15:0] drv_sp;
  logic [15:0] accel;
  logic [15:0] decel;
  logic [15:0] jerk;
  logic [15:0] mode3;
  logic        busy;
  logic        accelerating_flag;
  logic        constant_speed_flag;
  logic        decelerating_flag;
  logic        pulse;
  logic [15:0] speed;
  modport ctl (output start, dir_minus, fixed, dec_stop, hard_stop, slope_clr, pulses,
               init_sp, drv_sp, accel, decel, jerk, mode3,
               input busy, accelerating_flag, constant_speed_flag, decelerating_flag, pulse, speed);
  modport gen (input start, dir_minus, fixed, dec_stop, hard_stop, slope_clr, pulses,
               init_sp, drv_sp, accel, decel, jerk, mode3,
               output busy, accelerating_flag, constant_speed_flag, decelerating_flag, pulse, speed);
endinterface

//--- scdp_motor_model.sv
`timescale 1ns/1ps
// Motor driver stand-in: counts steps per axis and direction
module scdp_motor_model (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       clr_i,
  input wire logic [1:0] plus_i,
  input wire logic [1:0] minus_i
);
  logic [31:0] n_plus  [2];
  logic [31:0] n_minus [2];
  // Step counters, cleared between scenarios
  always_ff @(posedge clk_i or posedge rst_i) begin
    for (int a = 0; a < 2; a++) begin
      if (rst_i || clr_i) begin
        n_plus[a] <= 32'h0;
        n_minus[a] <= 32'h0;
      end else begin
        n_plus[a] <= n_plus[a] + 32'(plus_i[a]);
        n_minus[a] <= n_minus[a] + 32'(minus_i[a]);
      end
    end
  end
endmodule

//--- scdp_pkg.sv
package scdp_pkg;
  // Register indices on the plain port
  localparam logic [3:0] ADDR_CMD     = 4'h0;
  localparam logic [3:0] ADDR_MODE1   = 4'h1;
  localparam logic [3:0] ADDR_MODE2   = 4'h2;
  localparam logic [3:0] ADDR_MODE3   = 4'h3;
  localparam logic [3:0] ADDR_MAIN_ST = 4'h4;
  localparam logic [3:0] ADDR_ST1     = 4'h5;
  localparam logic [3:0] ADDR_PULSES  = 4'h6;
  localparam logic [3:0] ADDR_INIT_SP = 4'h7;
  localparam logic [3:0] ADDR_DRV_SP  = 4'h8;
  localparam logic [3:0] ADDR_ACCEL   = 4'h9;
  localparam logic [3:0] ADDR_JERK    = 4'ha;
  localparam logic [3:0] ADDR_DECEL   = 4'hb;
  localparam logic [3:0] ADDR_POS     = 4'hc;
  localparam logic [3:0] ADDR_CMP_P   = 4'hd;
  localparam logic [3:0] ADDR_CMP_M   = 4'he;
  // Command codes, axis bits in [9:8]
  localparam logic [7:0] CMD_FIX_PLUS  = 8'h20;
  localparam logic [7:0] CMD_FIX_MINUS = 8'h21;
  localparam logic [7:0] CMD_CONT_PLUS = 8'h22;
  localparam logic [7:0] CMD_CONT_MIN  = 8'h23;
  localparam logic [7:0] CMD_DEC_STOP  = 8'h26;
  localparam logic [7:0] CMD_SUD_STOP  = 8'h27;
  localparam logic [7:0] CMD_SLOPE_CLR = 8'h44;
  localparam int AXIS_LSB = 8;
  // Mode bit positions
  localparam int M1_STOP0_EN = 1;
  localparam int M1_STOP1_EN = 3;
  localparam int M1_STOP2_EN = 5;
  localparam int M2_SLIM_P   = 0;
  localparam int M2_SLIM_M   = 1;
  localparam int M2_LIM_DEC  = 2;
  localparam int M3_SEP_DEC  = 1;
  localparam int M3_SCURVE   = 2;
  localparam int M3_TRI_PREV = 5;
  // Status bit positions
  localparam int ST1_ACCELERATING_FLAG = 2;
  localparam int ST1_CONSTANT_SPEED_FLAG = 3;
  localparam int ST1_DECELERATING_FLAG = 4;
  // Reset values
  localparam logic [15:0] MODE_RST  = 16'h0000;
  localparam logic [15:0] SPEED_RST = 16'h0001;
  // Profile tick: 25 MHz core, 100 kHz speed update rate
  // Fast enough that a ramped stop ends within a few hundred cycles
  localparam int CLK_HZ      = 25000000;
  localparam int TICK_HZ     = 100000;
  localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
  localparam int PHASE_W     = 32;
  localparam logic signed [31:0] CMP_MIN = -32'sd1073741824;
  localparam logic signed [31:0] CMP_MAX = 32'sd1073741823;
endpackage

//--- scdp_profile.sv
`timescale 1ns/1ps
// One axis speed profile and pulse generator
module scdp_profile (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic tick_i,
  scdp_axis_if.gen  ax
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACC  = 2'b01,
    ST_CONSTANT_SPEED_FLAG = 2'b10,
    ST_DEC  = 2'b11
  } scdp_ph_e;

  scdp_ph_e    ph_q;
  logic [15:0] spd_q;
  logic [15:0] slope_q;
  logic [31:0] left_q;
  logic [31:0] ramp_q;
  logic [31:0] phase_q;
  logic        fix_q;
  logic        stopping_q;

  wire logic        scurve   = ax.mode3[scdp_pkg::M3_SCURVE];
  wire logic [15:0] dec_rate = ax.mode3[scdp_pkg::M3_SEP_DEC] ? ax.decel : ax.accel;
  // S-curve slope rises by the jerk each tick and is clipped at the acceleration rate
  wire logic [15:0] slope_up = (slope_q + ax.jerk > ax.accel) ? ax.accel
                                                              : 16'(slope_q + ax.jerk);
  wire logic [15:0] step_acc = scurve ? slope_up : ax.accel;
  wire logic [15:0] step_dec = scurve ? ((slope_q > dec_rate) ? dec_rate : slope_q) : dec_rate;
  // Triangle prevention: stop climbing once pulses left are down to twice the ramp
  wire logic        tri_cap   = ax.mode3[scdp_pkg::M3_TRI_PREV] && fix_q &&
                                (left_q <= {ramp_q[30:0], 1'b0});
  wire logic        need_dec  = stopping_q || (fix_q && (left_q <= ramp_q));
  wire logic [31:0] ph_sum    = phase_q + {16'h0000, spd_q};
  wire logic        pulse_now = (ph_q != ST_IDLE) && (ph_sum >= 32'(scdp_pkg::TICK_CYCLES));
  wire logic        last      = fix_q && pulse_now && (left_q <= 32'd1);
  wire logic [15:0] spd_up    = (spd_q + step_acc >= ax.drv_sp) ? ax.drv_sp
                                                                : 16'(spd_q + step_acc);
  wire logic [15:0] spd_dn    = (spd_q <= ax.init_sp + step_dec) ? ax.init_sp
                                                                 : 16'(spd_q - step_dec);

  // Pulse accumulator, count of pulses left, ramp length
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_q <= 32'h0;
      left_q  <= 32'h0;
      ramp_q  <= 32'h0;
      fix_q   <= 1'b0;
    end else if (ax.start && ph_q == ST_IDLE) begin
      phase_q <= 32'h0;
      left_q  <= ax.pulses;
      ramp_q  <= 32'h0;
      fix_q   <= ax.fixed;
    end else if (ph_q != ST_IDLE) begin
      phase_q <= pulse_now ? ph_sum - 32'(scdp_pkg::TICK_CYCLES) : ph_sum;
      if (pulse_now && fix_q && left_q != 32'h0) left_q <= left_q - 32'h1;
      if (pulse_now && ph_q == ST_ACC) ramp_q <= ramp_q + 32'h1;
    end
  end

  // Phase sequencer; any stop path always lands in idle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ph_q       <= ST_IDLE;
      spd_q      <= scdp_pkg::SPEED_RST;
      slope_q    <= 16'h0;
      stopping_q <= 1'b0;
    end else begin
      if (ax.slope_clr) slope_q <= 16'h0;
      if (ax.hard_stop || last) begin
        ph_q       <= ST_IDLE;
        stopping_q <= 1'b0;
        spd_q      <= ax.init_sp;
      end else if (ph_q == ST_IDLE) begin
        if (ax.start) begin
          ph_q  <= ST_ACC;
          spd_q <= ax.init_sp;
        end
      end else begin
        if (ax.dec_stop) stopping_q <= 1'b1;
        if (tick_i) begin
          unique case (ph_q)
            ST_ACC: begin
              spd_q <= spd_up;
              if (scurve) slope_q <= slope_up;
              if (need_dec) ph_q <= ST_DEC;
              else if (spd_up == ax.drv_sp || tri_cap) ph_q <= ST_CONSTANT_SPEED_FLAG;
            end
            ST_CONSTANT_SPEED_FLAG: begin
              if (need_dec) ph_q <= ST_DEC;
            end
            ST_DEC: begin
              spd_q <= spd_dn;
              if (scurve && slope_q != 16'h0) slope_q <= 16'(slope_q - 16'h1);
              // Speed floored at initial speed; a stop request ends here
              if (spd_dn == ax.init_sp && (stopping_q || !fix_q)) begin
                ph_q       <= ST_IDLE;
                stopping_q <= 1'b0;
              end else if (scurve && slope_q == 16'h0 && spd_dn != ax.init_sp) begin
                // Slope ran out above initial speed: one flat tick, then brake again
                slope_q <= ax.jerk | 16'h1;
              end
            end
            default: ph_q <= ST_IDLE;
          endcase
        end
      end
    end
  end

  assign ax.busy  = (ph_q != ST_IDLE);
  assign ax.accelerating_flag  = (ph_q == ST_ACC);
  // Flat slope while braking reads as constant speed
  assign ax.constant_speed_flag  = (ph_q == ST_CONSTANT_SPEED_FLAG) || (ph_q == ST_DEC && scurve && slope_q == 16'h0 &&
                                          spd_q != ax.init_sp);
  assign ax.decelerating_flag  = (ph_q == ST_DEC) && !ax.constant_speed_flag;
  assign ax.pulse = pulse_now;
  assign ax.speed = spd_q;
endmodule

//--- scdp_top.sv
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module scdp_top #(
  parameter int AXES = 2
) (
  input  wire logic            CORE_CLK_I,
  input  wire logic            RST_I,
  input  wire logic [3:0]      ADDR_I,
  input  wire logic [31:0]     WDATA_I,
  input  wire logic            WR_I,
  input  wire logic            RD_I,
  output logic      [31:0]     RDATA_O,
  input  wire logic [AXES-1:0] LIMIT_PLUS_I,
  input  wire logic [AXES-1:0] LIMIT_MINUS_I,
  input  wire logic [3*AXES-1:0] EXT_STOP_I,
  input  wire logic            EMERGENCY_STOP_I,
  input  wire logic [AXES-1:0] ALARM_I,
  output logic      [AXES-1:0] PULSE_PLUS_O,
  output logic      [AXES-1:0] PULSE_MINUS_O,
  output logic      [AXES-1:0] DRIVE_BUSY_O
);
  // Shared and per-axis registers
  logic [15:0] mode1_q, mode2_q, mode3_q;
  logic [31:0] pulses_q;
  logic [15:0] init_sp_q, drv_sp_q, accel_q, jerk_q, decel_q;
  logic signed [31:0] cmp_p_q, cmp_m_q;
  logic signed [31:0] pos_q [AXES];
  logic [AXES-1:0] dir_q;
  logic [15:0] tick_cnt_q;
  logic        tick_q;
  logic [31:0] rdata_d;

  wire logic       cmd_wr   = WR_I && (ADDR_I == scdp_pkg::ADDR_CMD);
  wire logic [7:0] cmd_code = WDATA_I[7:0];
  wire logic [AXES-1:0] cmd_axes = WDATA_I[scdp_pkg::AXIS_LSB +: AXES];

  // Speed update tick divider
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tick_cnt_q <= 16'h0;
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= (tick_cnt_q == 16'(scdp_pkg::TICK_CYCLES - 1));
      tick_cnt_q <= (tick_cnt_q == 16'(scdp_pkg::TICK_CYCLES - 1)) ? 16'h0
                                                                     : 16'(tick_cnt_q + 16'h1);
    end
  end

  // Register writes
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mode1_q   <= scdp_pkg::MODE_RST;
      mode2_q   <= scdp_pkg::MODE_RST;
      mode3_q   <= scdp_pkg::MODE_RST;
      pulses_q  <= 32'h0;
      init_sp_q <= scdp_pkg::SPEED_RST;
      drv_sp_q  <= scdp_pkg::SPEED_RST;
      accel_q   <= 16'h1;
      jerk_q    <= 16'h1;
      decel_q   <= 16'h1;
      cmp_p_q   <= scdp_pkg::CMP_MAX;
      cmp_m_q   <= scdp_pkg::CMP_MIN;
    end else if (WR_I) begin
      unique case (ADDR_I)
        scdp_pkg::ADDR_MODE1:   mode1_q   <= WDATA_I[15:0];
        scdp_pkg::ADDR_MODE2:   mode2_q   <= WDATA_I[15:0];
        scdp_pkg::ADDR_MODE3:   mode3_q   <= WDATA_I[15:0];
        scdp_pkg::ADDR_PULSES:  pulses_q  <= WDATA_I;
        scdp_pkg::ADDR_INIT_SP: init_sp_q <= WDATA_I[15:0];
        scdp_pkg::ADDR_DRV_SP:  drv_sp_q  <= WDATA_I[15:0];
        scdp_pkg::ADDR_ACCEL:   accel_q   <= WDATA_I[15:0];
        scdp_pkg::ADDR_JERK:    jerk_q    <= WDATA_I[15:0];
        scdp_pkg::ADDR_DECEL:   decel_q   <= WDATA_I[15:0];
        // Comparators only span 31 bits; sign-extend bit 30
        scdp_pkg::ADDR_CMP_P:   cmp_p_q   <= {WDATA_I[30], WDATA_I[30:0]};
        scdp_pkg::ADDR_CMP_M:   cmp_m_q   <= {WDATA_I[30], WDATA_I[30:0]};
        default: ;
      endcase
    end
  end

  // Per-axis profile, stop sources and position
  logic [AXES-1:0] busy_w, accelerating_flag_w, constant_speed_flag_w, decelerating_flag_w;
  genvar g;
  generate
    for (g = 0; g < AXES; g++) begin : g_axis
      scdp_axis_if ax ();
      wire logic mine     = cmd_wr && cmd_axes[g];
      wire logic go       = mine && (cmd_code == scdp_pkg::CMD_FIX_PLUS ||
                            cmd_code == scdp_pkg::CMD_FIX_MINUS ||
                            cmd_code == scdp_pkg::CMD_CONT_PLUS ||
                            cmd_code == scdp_pkg::CMD_CONT_MIN);
      wire logic go_minus = (cmd_code == scdp_pkg::CMD_FIX_MINUS ||
                             cmd_code == scdp_pkg::CMD_CONT_MIN);
      wire logic lim_hit  = dir_q[g] ? LIMIT_MINUS_I[g] : LIMIT_PLUS_I[g];
      wire logic lim_dec  = mode2_q[scdp_pkg::M2_LIM_DEC];
      // Software limits watch the compare pair in the travel direction
      wire logic slim_hit = dir_q[g] ? (mode2_q[scdp_pkg::M2_SLIM_M] && pos_q[g] < cmp_m_q)
                                     : (mode2_q[scdp_pkg::M2_SLIM_P] && pos_q[g] >= cmp_p_q);
      wire logic ext_hit  = (mode1_q[scdp_pkg::M1_STOP0_EN] && EXT_STOP_I[3*g])   ||
                            (mode1_q[scdp_pkg::M1_STOP1_EN] && EXT_STOP_I[3*g+1]) ||
                            (mode1_q[scdp_pkg::M1_STOP2_EN] && EXT_STOP_I[3*g+2]);
      assign ax.start     = go && !busy_w[g];
      assign ax.dir_minus = go_minus;
      assign ax.fixed     = (cmd_code == scdp_pkg::CMD_FIX_PLUS ||
                             cmd_code == scdp_pkg::CMD_FIX_MINUS);
      assign ax.dec_stop  = (mine && cmd_code == scdp_pkg::CMD_DEC_STOP) ||
                            (lim_hit && lim_dec) || slim_hit || ext_hit;
      assign ax.hard_stop = (mine && cmd_code == scdp_pkg::CMD_SUD_STOP) || EMERGENCY_STOP_I ||
                            (lim_hit && !lim_dec) || ALARM_I[g];
      assign ax.slope_clr = mine && (cmd_code == scdp_pkg::CMD_SLOPE_CLR);
      assign ax.pulses    = pulses_q;
      assign ax.init_sp   = init_sp_q;
      assign ax.drv_sp    = drv_sp_q;
      assign ax.accel     = accel_q;
      assign ax.decel     = decel_q;
      assign ax.jerk      = jerk_q;
      assign ax.mode3     = mode3_q;
      assign busy_w[g]    = ax.busy;
      assign accelerating_flag_w[g]    = ax.accelerating_flag;
      assign constant_speed_flag_w[g]    = ax.constant_speed_flag;
      assign decelerating_flag_w[g]    = ax.decelerating_flag;

      scdp_profile u_prof (
        .clk_i  (CORE_CLK_I),
        .rst_i  (RST_I),
        .tick_i (tick_q),
        .ax     (ax)
      );

      // Direction latch, position count and registered pins
      always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
          dir_q[g]         <= 1'b0;
          pos_q[g]         <= 32'sh0;
          PULSE_PLUS_O[g]  <= 1'b0;
          PULSE_MINUS_O[g] <= 1'b0;
          DRIVE_BUSY_O[g]  <= 1'b0;
        end else begin
          if (ax.start) dir_q[g] <= ax.dir_minus;
          if (ax.pulse) pos_q[g] <= dir_q[g] ? pos_q[g] - 32'sh1 : pos_q[g] + 32'sh1;
          PULSE_PLUS_O[g]  <= ax.pulse && !dir_q[g];
          PULSE_MINUS_O[g] <= ax.pulse && dir_q[g];
          DRIVE_BUSY_O[g]  <= ax.busy;
        end
      end
    end
  endgenerate

  // Read mux; status one packs both axes, axis 1 at bit 8
  logic [15:0] st1_w;
  always_comb begin
    st1_w = 16'h0;
    for (int a = 0; a < AXES; a++) begin
      st1_w[8*a + scdp_pkg::ST1_ACCELERATING_FLAG] = accelerating_flag_w[a];
      st1_w[8*a + scdp_pkg::ST1_CONSTANT_SPEED_FLAG] = constant_speed_flag_w[a];
      st1_w[8*a + scdp_pkg::ST1_DECELERATING_FLAG] = decelerating_flag_w[a];
    end
  end
  assign rdata_d = (ADDR_I == scdp_pkg::ADDR_MODE1)   ? {16'h0, mode1_q}  :
                   (ADDR_I == scdp_pkg::ADDR_MODE2)   ? {16'h0, mode2_q}  :
                   (ADDR_I == scdp_pkg::ADDR_MODE3)   ? {16'h0, mode3_q}  :
                   (ADDR_I == scdp_pkg::ADDR_MAIN_ST) ? 32'(busy_w)       :
                   (ADDR_I == scdp_pkg::ADDR_ST1)     ? {16'h0, st1_w}    :
                   (ADDR_I == scdp_pkg::ADDR_PULSES)  ? pulses_q          :
                   (ADDR_I == scdp_pkg::ADDR_POS)     ? pos_q[0]          :
                   (ADDR_I == scdp_pkg::ADDR_CMP_P)   ? cmp_p_q           :
                   (ADDR_I == scdp_pkg::ADDR_CMP_M)   ? cmp_m_q           : 32'h0;

  // Read data stand one cycle after each RD_I cycle, zero otherwise
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) RDATA_O <= 32'h0;
    else       RDATA_O <= RD_I ? rdata_d : 32'h0;
  end
endmodule

//--- scdp_top_assertions.sv
`timescale 1ns/1ps
// Pin-level checks of drive start, stop and pulse ownership
module scdp_chk #(
  parameter int AXES = 2
) (
  input wire logic              CORE_CLK_I,
  input wire logic              RST_I,
  input wire logic [3:0]        ADDR_I,
  input wire logic [31:0]       WDATA_I,
  input wire logic              WR_I,
  input wire logic              RD_I,
  input wire logic [31:0]       RDATA_O,
  input wire logic [AXES-1:0]   LIMIT_PLUS_I,
  input wire logic [AXES-1:0]   LIMIT_MINUS_I,
  input wire logic [3*AXES-1:0] EXT_STOP_I,
  input wire logic              EMERGENCY_STOP_I,
  input wire logic [AXES-1:0]   ALARM_I,
  input wire logic [AXES-1:0]   PULSE_PLUS_O,
  input wire logic [AXES-1:0]   PULSE_MINUS_O,
  input wire logic [AXES-1:0]   DRIVE_BUSY_O
);
  // Command write aimed at axis 0
  wire logic       cmd_ax0;
  wire logic [7:0] code;
  assign cmd_ax0 = WR_I && ADDR_I == scdp_pkg::ADDR_CMD && WDATA_I[8];
  assign code = WDATA_I[7:0];
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  // Busy answers a fixed plus start two edges later, never rises without an axis 0 command
  property p_start_busy;
    cmd_ax0 && code == scdp_pkg::CMD_FIX_PLUS && !DRIVE_BUSY_O[0] |-> ##2 DRIVE_BUSY_O[0];
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start without busy");
  property p_busy_cause;
    $rose(DRIVE_BUSY_O[0]) |-> $past(cmd_ax0, 2);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without command");
  property p_slope_clr;
    cmd_ax0 && code == scdp_pkg::CMD_SLOPE_CLR && !DRIVE_BUSY_O[0] |-> ##2 !DRIVE_BUSY_O[0];
  endproperty
  a_slope_clr: assert property (p_slope_clr) else $error("slope clear started a drive");
  // One direction at a time; pulses only while busy
  property p_dir;
    PULSE_MINUS_O[0] |-> !PULSE_PLUS_O[0];
  endproperty
  a_dir: assert property (p_dir) else $error("both directions pulsed");
  property p_pulse_busy0;
    PULSE_PLUS_O[0] || PULSE_MINUS_O[0] |-> DRIVE_BUSY_O[0] || $past(DRIVE_BUSY_O[0]);
  endproperty
  a_pulse_busy0: assert property (p_pulse_busy0) else $error("axis 0 pulse while idle");
  property p_pulse_busy1;
    PULSE_PLUS_O[1] || PULSE_MINUS_O[1] |-> DRIVE_BUSY_O[1] || $past(DRIVE_BUSY_O[1]);
  endproperty
  a_pulse_busy1: assert property (p_pulse_busy1) else $error("axis 1 pulse while idle");
  // Sudden stop sources end the drive with no ramp
  property p_emerg;
    $rose(EMERGENCY_STOP_I) |-> ##[1:3] DRIVE_BUSY_O == '0;
  endproperty
  a_emerg: assert property (p_emerg) else $error("emergency stop too slow");
  property p_emerg_quiet;
    EMERGENCY_STOP_I [*3] |-> PULSE_PLUS_O == '0 && PULSE_MINUS_O == '0;
  endproperty
  a_emerg_quiet: assert property (p_emerg_quiet) else $error("pulse during emergency");
  property p_alarm;
    $rose(ALARM_I[0]) |-> ##[1:3] !DRIVE_BUSY_O[0];
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm stop too slow");
  property p_sudden;
    cmd_ax0 && code == scdp_pkg::CMD_SUD_STOP |-> ##[1:3] !DRIVE_BUSY_O[0];
  endproperty
  a_sudden: assert property (p_sudden) else $error("sudden stop too slow");
endmodule
bind scdp_top scdp_chk #(.AXES(AXES)) scdp_chk_i (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .LIMIT_PLUS_I(LIMIT_PLUS_I), .LIMIT_MINUS_I(LIMIT_MINUS_I), .EXT_STOP_I(EXT_STOP_I),
  .EMERGENCY_STOP_I(EMERGENCY_STOP_I), .ALARM_I(ALARM_I), .PULSE_PLUS_O(PULSE_PLUS_O),
  .PULSE_MINUS_O(PULSE_MINUS_O), .DRIVE_BUSY_O(DRIVE_BUSY_O));

//--- scdp_top_tb.sv
`timescale 1ns/1ps
module scdp_top_tb;
  logic        CORE_CLK_I = 1'b0;
  logic        RST_I = 1'b1;
  logic [3:0]  ADDR_I = 4'h0;
  logic [31:0] WDATA_I = 32'h0;
  logic        WR_I = 1'b0;
  logic        RD_I = 1'b0;
  logic [1:0]  LIMIT_PLUS_I = 2'h0;
  logic [1:0]  LIMIT_MINUS_I = 2'h0;
  logic [1:0]  ALARM_I = 2'h0;
  logic [5:0]  EXT_STOP_I = 6'h0;
  logic        EMERGENCY_STOP_I = 1'b0;
  logic        cnt_clr = 1'b0;
  wire  [31:0] RDATA_O;
  wire  [1:0]  PULSE_PLUS_O;
  wire  [1:0]  PULSE_MINUS_O;
  wire  [1:0]  DRIVE_BUSY_O;
  int          n_errors = 0;
  int          compares = 0;
  logic [31:0] rv;
  logic [31:0] modes [3] = '{32'h0, 32'h4, 32'h26};
  scdp_top #(.AXES(2)) scdp_top_i (.CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .LIMIT_PLUS_I(LIMIT_PLUS_I), .LIMIT_MINUS_I(LIMIT_MINUS_I), .EXT_STOP_I(EXT_STOP_I),
    .EMERGENCY_STOP_I(EMERGENCY_STOP_I), .ALARM_I(ALARM_I), .PULSE_PLUS_O(PULSE_PLUS_O),
    .PULSE_MINUS_O(PULSE_MINUS_O), .DRIVE_BUSY_O(DRIVE_BUSY_O));
  scdp_motor_model scdp_motor_model_i (.clk_i(CORE_CLK_I), .rst_i(RST_I), .clr_i(cnt_clr),
    .plus_i(PULSE_PLUS_O), .minus_i(PULSE_MINUS_O));
  // 25 MHz core clock
  initial begin
    forever #20 CORE_CLK_I = ~CORE_CLK_I;
  end
  task automatic close_out();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CORE_CLK_I);
    #1;
  endtask
  // Plain-port bus cycles, one strobe cycle each
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CORE_CLK_I);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge CORE_CLK_I);
    WR_I <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge CORE_CLK_I);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge CORE_CLK_I);
    RD_I <= 1'b0;
    #1;
    d = RDATA_O;
  endtask
  task automatic cmd(input int ax, input logic [7:0] c);
    wr(scdp_pkg::ADDR_CMD, (32'h100 << ax) | 32'(c));
  endtask
  // Slope clear always goes just ahead of a drive command
  task automatic drive(input int ax, input logic [7:0] c);
    cmd(ax, scdp_pkg::CMD_SLOPE_CLR);
    cmd(ax, c);
  endtask
  task automatic clr();
    @(posedge CORE_CLK_I);
    cnt_clr <= 1'b1;
    @(posedge CORE_CLK_I);
    cnt_clr <= 1'b0;
  endtask
  // Bounded wait on the busy pin; running out is a mismatch
  task automatic wait_busy(input int ax, input logic lvl, input int bound);
    int n;
    n = 0;
    while (DRIVE_BUSY_O[ax] !== lvl && n < bound) begin
      tick(1);
      n++;
    end
    chk("busy_wait", 32'(lvl), 32'(DRIVE_BUSY_O[ax]));
    if (DRIVE_BUSY_O[ax] !== lvl) begin
      close_out();
    end
  endtask
  initial begin
    repeat (20) @(posedge CORE_CLK_I);
    RST_I <= 1'b0;
    rd(scdp_pkg::ADDR_MODE3, rv);
    chk("mode3_rst", 32'(scdp_pkg::MODE_RST), rv);
    rd(scdp_pkg::ADDR_CMP_P, rv);
    chk("cmp_p_rst", scdp_pkg::CMP_MAX, rv);
    wr(4'hf, 32'hffff_ffff);
    rd(4'hf, rv);
    chk("unmapped", 32'h0, rv);
    // Flat profile: a step every five cycles
    wr(scdp_pkg::ADDR_INIT_SP, 32'h32);
    wr(scdp_pkg::ADDR_DRV_SP, 32'h32);
    wr(scdp_pkg::ADDR_PULSES, 32'h8); // Counts kept at two or more
    // Fixed drives in each direction under each profile mode
    for (int m = 0; m < 3; m++) begin
      for (int c = 0; c < 2; c++) begin
        wr(scdp_pkg::ADDR_MODE3, modes[m]);
        clr();
        drive(0, c ? scdp_pkg::CMD_FIX_MINUS : scdp_pkg::CMD_FIX_PLUS);
        wait_busy(0, 1'b1, 10);
        wait_busy(0, 1'b0, 3000);
        chk("plus_cnt", c ? 32'h0 : 32'h8, scdp_motor_model_i.n_plus[0]);
        chk("minus_cnt", c ? 32'h8 : 32'h0, scdp_motor_model_i.n_minus[0]);
      end
    end
    cmd(0, scdp_pkg::CMD_SLOPE_CLR);
    tick(4);
    chk("clr_idle", 32'h0, 32'(DRIVE_BUSY_O));
    // Continuous run on axis 1: status, refused start, ramped stop
    clr();
    drive(1, scdp_pkg::CMD_CONT_PLUS);
    wait_busy(1, 1'b1, 10);
    tick(300);
    rd(scdp_pkg::ADDR_ST1, rv);
    chk("st1_phase", 32'h2, 32'(rv[12:10]));
    rd(scdp_pkg::ADDR_MAIN_ST, rv);
    chk("main_busy", 32'h2, 32'(rv[1:0]));
    cmd(1, scdp_pkg::CMD_FIX_MINUS);
    tick(50);
    chk("refused", 32'h0, scdp_motor_model_i.n_minus[1]);
    chk("cont_run", 32'h1, 32'(scdp_motor_model_i.n_plus[1] > 32'ha));
    cmd(1, scdp_pkg::CMD_DEC_STOP);
    wait_busy(1, 1'b0, 3000);
    // External stops: ignored until enabled
    drive(0, scdp_pkg::CMD_CONT_PLUS);
    wait_busy(0, 1'b1, 10);
    @(posedge CORE_CLK_I);
    EXT_STOP_I <= 6'h3f;
    tick(50);
    chk("ext_off", 32'h1, 32'(DRIVE_BUSY_O[0]));
    wr(scdp_pkg::ADDR_MODE1, 32'h2a);
    wait_busy(0, 1'b0, 3000);
    @(posedge CORE_CLK_I);
    EXT_STOP_I <= 6'h0;
    wr(scdp_pkg::ADDR_MODE1, 32'h0);
    // Sudden, emergency, alarm, limit sudden, limit ramped
    for (int s = 0; s < 5; s++) begin
      wr(scdp_pkg::ADDR_MODE2, s == 4 ? 32'h4 : 32'h0);
      drive(0, scdp_pkg::CMD_CONT_PLUS);
      wait_busy(0, 1'b1, 10);
      tick(20);
      @(posedge CORE_CLK_I);
      case (s)
        0: cmd(0, scdp_pkg::CMD_SUD_STOP);
        1: EMERGENCY_STOP_I <= 1'b1;
        2: ALARM_I <= 2'b01;
        default: LIMIT_PLUS_I <= 2'b01;
      endcase
      wait_busy(0, 1'b0, s == 4 ? 3000 : 5);
      @(posedge CORE_CLK_I);
      EMERGENCY_STOP_I <= 1'b0;
      ALARM_I <= 2'b00;
      LIMIT_PLUS_I <= 2'b00;
    end
    // Ramped stop landing near the last step
    drive(0, scdp_pkg::CMD_FIX_PLUS);
    tick(35);
    cmd(0, scdp_pkg::CMD_DEC_STOP);
    wait_busy(0, 1'b0, 200);
    // Software limits; bit 30 set makes the plus bound negative
    wr(scdp_pkg::ADDR_CMP_P, 32'h7fff_ffff);
    wr(scdp_pkg::ADDR_CMP_M, 32'h3fff_ffff);
    wr(scdp_pkg::ADDR_MODE2, 32'h3);
    for (int c = 0; c < 2; c++) begin
      drive(0, c ? scdp_pkg::CMD_CONT_MIN : scdp_pkg::CMD_CONT_PLUS);
      tick(20);
      wait_busy(0, 1'b0, 3000);
    end
    close_out();
  end
endmodule
